// File: rtl/sba_top.sv
`timescale 1ns/10ps
module sba_top (
  input wire logic clk, // System clock
  input wire logic rst_n, // Global reset, synchronous
  input wire logic cfg_wr, // Config byte write strobe
  input wire logic [7:0] cfg_addr, // Config byte offset
  input wire logic [7:0] cfg_wdata, // Config write data
  output logic [7:0] cfg_rdata, // Config read data, one cycle late
  input wire logic scl_in, // Serial clock pin level
  output logic scl_out, // Serial clock drive value
  output logic scl_oe, // Serial clock drive enable
  input wire logic sda_in, // Serial data pin level
  output logic sda_out, // Serial data drive value
  output logic sda_oe // Serial data drive enable
);
  import sba_pkg::*;

  typedef enum {S_IDLE, S_START, S_TX, S_ACK, S_RX, S_MACK, S_STOP} sba_state_t;
  typedef enum {G_ADDR1, G_INDEX, G_DATA, G_ADDR2, G_RDATA} sba_stage_t;

  logic [7:0] serial_byte_value, target_byte_offset, serial_target_and_direction;
  logic short_protocol_select, fast_clock_test, request_in_progress, req_err;
  logic launch, wr_ok, err_set;
  logic [7:0] shift;
  logic [2:0] bit_cnt;
  sba_state_t state;
  sba_stage_t stage;
  sba_bit_if bus ();

  sba_bit_engine u_eng (
    .clk(clk),
    .rst_n(rst_n),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .scl_oe(scl_oe),
    .sda_oe(sda_oe),
    .bus(bus)
  );

  assign bus.fast = fast_clock_test;

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Config writes are ignored while a request runs, except the error-bit clear
  assign wr_ok = cfg_wr && !request_in_progress;
  assign launch = wr_ok && cfg_addr == SBA_OFF_TARGET;
  assign err_set = state == S_ACK && bus.done && bus.rx;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      target_byte_offset <= SBA_RST_INDEX;
      serial_target_and_direction <= SBA_RST_TARGET;
      short_protocol_select <= SBA_RST_CTRL[SBA_SHORT_BIT];
      fast_clock_test <= SBA_RST_CTRL[SBA_FAST_BIT];
    end
    else if (wr_ok)
    begin
      if (cfg_addr == SBA_OFF_INDEX)
        target_byte_offset <= cfg_wdata;
      if (cfg_addr == SBA_OFF_TARGET)
        serial_target_and_direction <= cfg_wdata;
      if (cfg_addr == SBA_OFF_CTRL)
      begin
        short_protocol_select <= cfg_wdata[SBA_SHORT_BIT];
        fast_clock_test <= cfg_wdata[SBA_FAST_BIT];
      end
    end
  end

  // Set wins over the write-one clear
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      req_err <= SBA_RST_CTRL[SBA_ERR_BIT];
    else if (err_set)
      req_err <= 1'b1;
    else if (cfg_wr && cfg_addr == SBA_OFF_CTRL && cfg_wdata[SBA_ERR_BIT])
      req_err <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      cfg_rdata <= 8'h00;
    else
    begin
      case (cfg_addr)
        SBA_OFF_VALUE: cfg_rdata <= serial_byte_value;
        SBA_OFF_INDEX: cfg_rdata <= target_byte_offset;
        SBA_OFF_TARGET: cfg_rdata <= serial_target_and_direction;
        SBA_OFF_CTRL: cfg_rdata <= {short_protocol_select, 1'b0, request_in_progress,
                                    2'b00, fast_clock_test, req_err, 1'b0};
        default: cfg_rdata <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    scl_out <= 1'b0;
    sda_out <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Byte sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state <= S_IDLE;
      stage <= G_ADDR1;
      request_in_progress <= 1'b0;
      serial_byte_value <= SBA_RST_VALUE;
      shift <= 8'h00;
      bit_cnt <= 3'h0;
      bus.req <= 1'b0;
      bus.cmd <= BC_START;
      bus.tx <= 1'b0;
    end
    else
    begin
      bus.req <= 1'b0;
      if (wr_ok && cfg_addr == SBA_OFF_VALUE)
        serial_byte_value <= cfg_wdata;
      case (state)
        S_IDLE:
          if (launch)
          begin
            request_in_progress <= 1'b1;
            state <= S_START;
            stage <= G_ADDR1;
            bus.req <= 1'b1;
            bus.cmd <= BC_START;
          end
        S_START:
          if (bus.done)
          begin
            // Normal read sends the index with a write address first
            if (stage == G_ADDR2)
              shift <= {serial_target_and_direction[7:1], 1'b1};
            else if (short_protocol_select)
              shift <= serial_target_and_direction;
            else
              shift <= {serial_target_and_direction[7:1], 1'b0};
            bit_cnt <= 3'h0;
            state <= S_TX;
            bus.req <= 1'b1;
            bus.cmd <= BC_WRITE;
            bus.tx <= serial_target_and_direction[7];
          end
        S_TX:
          if (bus.done)
          begin
            bus.req <= 1'b1;
            if (bit_cnt == 3'h7)
            begin
              state <= S_ACK;
              bus.cmd <= BC_READ;
            end
            else
            begin
              shift <= {shift[6:0], 1'b0};
              bit_cnt <= bit_cnt + 3'h1;
              bus.cmd <= BC_WRITE;
              bus.tx <= shift[6];
            end
          end
        S_ACK:
          if (bus.done)
          begin
            bus.req <= 1'b1;
            bit_cnt <= 3'h0;
            if (bus.rx)
            begin
              state <= S_STOP;
              bus.cmd <= BC_STOP;
            end
            else if (stage == G_ADDR2 || (stage == G_ADDR1 && short_protocol_select &&
                     serial_target_and_direction[SBA_DIR_BIT]))
            begin
              stage <= G_RDATA;
              state <= S_RX;
              bus.cmd <= BC_READ;
            end
            else if (stage == G_ADDR1 && !short_protocol_select)
            begin
              stage <= G_INDEX;
              shift <= target_byte_offset;
              state <= S_TX;
              bus.cmd <= BC_WRITE;
              bus.tx <= target_byte_offset[7];
            end
            else if (stage == G_INDEX && serial_target_and_direction[SBA_DIR_BIT])
            begin
              stage <= G_ADDR2;
              state <= S_START;
              bus.cmd <= BC_START;
            end
            else if (stage != G_DATA)
            begin
              stage <= G_DATA;
              shift <= serial_byte_value;
              state <= S_TX;
              bus.cmd <= BC_WRITE;
              bus.tx <= serial_byte_value[7];
            end
            else
            begin
              state <= S_STOP;
              bus.cmd <= BC_STOP;
            end
          end
        S_RX:
          if (bus.done)
          begin
            bus.req <= 1'b1;
            shift <= {shift[6:0], bus.rx};
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == 3'h7)
            begin
              serial_byte_value <= {shift[6:0], bus.rx};
              state <= S_MACK;
              bus.cmd <= BC_WRITE;
              bus.tx <= 1'b1;
            end
            else
              bus.cmd <= BC_READ;
          end
        S_MACK:
          if (bus.done)
          begin
            state <= S_STOP;
            bus.req <= 1'b1;
            bus.cmd <= BC_STOP;
          end
        S_STOP:
          if (bus.done)
          begin
            state <= S_IDLE;
            request_in_progress <= 1'b0;
          end
        default: state <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_launch;
    launch && state == S_IDLE;
  endsequence
  sequence s_ack_seen;
    state == S_ACK && bus.done;
  endsequence

  property p_launch_busy;
    @(posedge clk) disable iff (!rst_n) s_launch |=> request_in_progress && state == S_START;
  endproperty
  a_launch_busy: assert property (p_launch_busy) else $error("busy not set on launch");

  property p_busy_clear;
    @(posedge clk) disable iff (!rst_n)
      request_in_progress && !(state == S_STOP && bus.done) |=> request_in_progress;
  endproperty
  a_busy_clear: assert property (p_busy_clear) else $error("busy fell early");

  property p_rx_capture;
    @(posedge clk) disable iff (!rst_n)
      state == S_RX && bus.done && bit_cnt == 3'h7 |=>
      serial_byte_value[7:1] == $past(shift[6:0]) && serial_byte_value[0] == $past(bus.rx) &&
      state == S_MACK;
  endproperty
  a_rx_capture: assert property (p_rx_capture) else $error("read byte not captured");

  property p_index_sent;
    @(posedge clk) disable iff (!rst_n)
      s_ack_seen ##0 (!bus.rx && stage == G_ADDR1 && !short_protocol_select) |=>
      shift == target_byte_offset && stage == G_INDEX && bus.tx == shift[7];
  endproperty
  a_index_sent: assert property (p_index_sent) else $error("index not loaded");

  property p_addr_bits;
    @(posedge clk) disable iff (!rst_n)
      state == S_START && bus.done |=> shift[7:1] == serial_target_and_direction[7:1];
  endproperty
  a_addr_bits: assert property (p_addr_bits) else $error("address bits wrong");

  property p_dir_bit;
    @(posedge clk) disable iff (!rst_n)
      state == S_START && bus.done && short_protocol_select && stage == G_ADDR1 |=>
      shift[0] == serial_target_and_direction[SBA_DIR_BIT];
  endproperty
  a_dir_bit: assert property (p_dir_bit) else $error("direction bit wrong");

  property p_read_restart;
    @(posedge clk) disable iff (!rst_n)
      s_ack_seen ##0 (!bus.rx && stage == G_INDEX && serial_target_and_direction[0]) |=>
      state == S_START && stage == G_ADDR2 && bus.req && bus.cmd == BC_START;
  endproperty
  a_read_restart: assert property (p_read_restart) else $error("no restart on read");

  property p_nack_abort;
    @(posedge clk) disable iff (!rst_n)
      s_ack_seen ##0 bus.rx |=> req_err && state == S_STOP && bus.cmd == BC_STOP;
  endproperty
  a_nack_abort: assert property (p_nack_abort) else $error("missing ack not handled");

  property p_reset_clear;
    @(posedge clk) disable iff (!rst_n)
      $rose(rst_n) |-> serial_byte_value == 8'h00 && target_byte_offset == 8'h00 &&
      serial_target_and_direction == 8'h00;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("registers not cleared");
endmodule

// File: inc/sba_pkg.sv
package sba_pkg;
  // ----------------------------------------------------------------
  // Register offsets in configuration space
  // ----------------------------------------------------------------
  localparam logic [7:0] SBA_OFF_VALUE = 8'hb0;
  localparam logic [7:0] SBA_OFF_INDEX = 8'hb1;
  localparam logic [7:0] SBA_OFF_TARGET = 8'hb2;
  localparam logic [7:0] SBA_OFF_CTRL = 8'hb3;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] SBA_RST_VALUE = 8'h00;
  localparam logic [7:0] SBA_RST_INDEX = 8'h00;
  localparam logic [7:0] SBA_RST_TARGET = 8'h00;
  localparam logic [7:0] SBA_RST_CTRL = 8'h00;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SBA_DIR_BIT = 0;
  localparam int SBA_SHORT_BIT = 7;
  localparam int SBA_BUSY_BIT = 5;
  localparam int SBA_FAST_BIT = 2;
  localparam int SBA_ERR_BIT = 1;
  // ----------------------------------------------------------------
  // Serial clock timing
  // ----------------------------------------------------------------
  localparam int SBA_CLK_PERIOD_NS = 10;
  localparam int SBA_SCL_NORM_PERIOD_NS = 10000;
  localparam int SBA_SCL_FAST_PERIOD_NS = 2500;
  localparam int SBA_QTR_W = 9;
  localparam logic [SBA_QTR_W-1:0] SBA_QTR_NORM =
    SBA_QTR_W'(SBA_SCL_NORM_PERIOD_NS / (4 * SBA_CLK_PERIOD_NS));
  localparam logic [SBA_QTR_W-1:0] SBA_QTR_FAST =
    SBA_QTR_W'(SBA_SCL_FAST_PERIOD_NS / (4 * SBA_CLK_PERIOD_NS));
  // ----------------------------------------------------------------
  // Bit-level commands
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {BC_START, BC_STOP, BC_WRITE, BC_READ} sba_bitcmd_t;
endpackage

// File: inc/sba_bit_if.sv
`timescale 1ns/10ps
interface sba_bit_if;
  logic req;
  sba_pkg::sba_bitcmd_t cmd;
  logic tx;
  logic fast;
  logic done;
  logic rx;
  modport eng (input req, input cmd, input tx, input fast, output done, output rx);
  modport seq (output req, output cmd, output tx, output fast, input done, input rx);
endinterface

// File: rtl/sba_bit_engine.sv
`timescale 1ns/10ps
module sba_bit_engine (
  input wire logic clk, // System clock
  input wire logic rst_n, // Synchronous reset
  input wire logic scl_in, // Serial clock pin level
  input wire logic sda_in, // Serial data pin level
  output logic scl_oe, // Serial clock pulled low
  output logic sda_oe, // Serial data pulled low
  sba_bit_if.eng bus // Bit command port
);
  import sba_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic scl_meta, scl_sync, sda_meta, sda_sync;
  always_ff @(posedge clk)
  begin
    scl_meta <= scl_in;
    scl_sync <= scl_meta;
    sda_meta <= sda_in;
    sda_sync <= sda_meta;
  end

  // ----------------------------------------------------------------
  // Quarter-bit sequencer
  // ----------------------------------------------------------------
  logic active, stall, tick, next_scl_lo, next_sda_lo;
  logic [1:0] phase;
  logic [SBA_QTR_W-1:0] div, qtr;
  sba_bitcmd_t cmd;
  logic tx;

  assign qtr = bus.fast ? SBA_QTR_FAST : SBA_QTR_NORM;
  // Wait while a target holds the clock low
  assign stall = !scl_oe && !scl_sync;
  assign tick = active && !stall && div == '0;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      active <= 1'b0;
      phase <= 2'h0;
      div <= '0;
      cmd <= BC_START;
      tx <= 1'b0;
    end
    else if (!active)
    begin
      if (bus.req)
      begin
        active <= 1'b1;
        cmd <= bus.cmd;
        tx <= bus.tx;
        phase <= 2'h0;
        div <= qtr;
      end
    end
    else if (!stall)
    begin
      if (div != '0)
        div <= div - 1'b1;
      else
      begin
        div <= qtr;
        phase <= phase + 2'h1;
        if (phase == 2'h3)
          active <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      bus.done <= 1'b0;
      bus.rx <= 1'b0;
    end
    else
    begin
      bus.done <= tick && phase == 2'h3;
      if (tick && phase == 2'h2)
        bus.rx <= sda_sync;
    end
  end

  // ----------------------------------------------------------------
  // Line drive per command and phase
  // ----------------------------------------------------------------
  always_comb
  begin
    next_scl_lo = scl_oe;
    next_sda_lo = sda_oe;
    if (active)
    begin
      case (cmd)
        BC_START:
          case (phase)
            2'h0: next_sda_lo = 1'b0;
            2'h1: next_scl_lo = 1'b0;
            2'h2: next_sda_lo = 1'b1;
            default: next_scl_lo = 1'b1;
          endcase
        BC_STOP:
          case (phase)
            2'h0: next_sda_lo = 1'b1;
            2'h1: next_scl_lo = 1'b0;
            2'h2: next_sda_lo = 1'b0;
            default: next_scl_lo = 1'b0;
          endcase
        default:
          case (phase)
            2'h0:
            begin
              next_scl_lo = 1'b1;
              next_sda_lo = (cmd == BC_WRITE) ? !tx : 1'b0;
            end
            2'h1: next_scl_lo = 1'b0;
            2'h2: next_scl_lo = 1'b0;
            default: next_scl_lo = 1'b1;
          endcase
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end
    else
    begin
      scl_oe <= next_scl_lo;
      sda_oe <= next_sda_lo;
    end
  end
endmodule

// File: bench/sba_target_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Byte-addressed serial target, open drain, optional clock stretch
// ----------------------------------------------------------------
module sba_target_model #(
  parameter logic [6:0] DEV_ADDR = 7'h50
) (
  input wire logic scl_w, // Serial clock wire level
  input wire logic sda_w, // Serial data wire level
  input wire logic [15:0] stretch_ns, // Low hold after each clock fall
  output logic scl_lo, // Pulls the clock wire low
  output logic sda_lo // Pulls the data wire low
);
  logic [7:0] mem [256];
  logic [7:0] sh;
  logic [7:0] ptr;
  logic [7:0] out;
  logic sel;
  logic rd;
  int cnt;
  int nb;
  initial
  begin
    scl_lo = 1'b0;
    sda_lo = 1'b0;
    cnt = 0;
    nb = 0;
    sel = 1'b0;
    rd = 1'b0;
    ptr = 8'h00;
    for (int i = 0; i < 256; i++)
      mem[i] = 8'(i) ^ 8'h5a;
  end
  // Start: data falls while clock is high
  always @(negedge sda_w)
    if (scl_w === 1'b1)
    begin
      cnt = 0;
      nb = 0;
      sda_lo = 1'b0;
    end
  // Stop: data rises while clock is high; byte count kept for the bench
  always @(posedge sda_w)
    if (scl_w === 1'b1)
    begin
      cnt = 0;
      sda_lo = 1'b0;
    end
  always @(posedge scl_w)
  begin
    sh = {sh[6:0], sda_w};
    cnt++;
  end
  always @(negedge scl_w)
    if (stretch_ns != 16'h0000 && !scl_lo)
    begin
      scl_lo = 1'b1;
      #(stretch_ns);
      scl_lo = 1'b0;
    end
  always @(negedge scl_w)
  begin
    if (cnt == 8)
    begin
      if (nb == 0)
      begin
        sel = (sh[7:1] == DEV_ADDR);
        rd = sh[0];
        sda_lo = sel;
      end
      else if (!rd && sel)
      begin
        // First byte after the address sets the pointer
        if (nb == 1)
          ptr = sh;
        else
        begin
          mem[ptr] = sh;
          ptr++;
        end
        sda_lo = 1'b1;
      end
      else
        sda_lo = 1'b0;
      nb++;
    end
    else if (cnt == 9)
    begin
      cnt = 0;
      sda_lo = 1'b0;
      if (rd && sel && nb == 1)
      begin
        out = mem[ptr];
        ptr++;
      end
    end
    if (rd && sel && nb == 1 && cnt < 8)
      sda_lo = ~out[7 - cnt];
  end
endmodule

// File: bench/tb_sba_top.sv
`timescale 1ns/10ps
`define CHK(got, exp) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) \
    begin \
      n_errors++; \
      $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end
module tb_sba_top;
  import sba_pkg::*;
  logic clk;
  logic rst_n;
  logic cfg_wr;
  logic [7:0] cfg_addr;
  logic [7:0] cfg_wdata;
  logic [7:0] cfg_rdata;
  logic scl_out;
  logic scl_oe;
  logic sda_out;
  logic sda_oe;
  logic scl_lo;
  logic sda_lo;
  logic scl_w;
  logic sda_w;
  logic [15:0] stretch_ns;
  int n_errors;
  int num_checks;
  int cycles;
  // Open-drain wires with pull-ups
  assign scl_w = !(scl_oe === 1'b1 || scl_lo === 1'b1);
  assign sda_w = !(sda_oe === 1'b1 || sda_lo === 1'b1);
  sba_top i_dut (.clk(clk), .rst_n(rst_n), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .scl_in(scl_w), .scl_out(scl_out),
    .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe));
  sba_target_model #(.DEV_ADDR(7'h50)) i_tgt (.scl_w(scl_w), .sda_w(sda_w),
    .stretch_ns(stretch_ns), .scl_lo(scl_lo), .sda_lo(sda_lo));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // Register access and helpers
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_wdata = d;
    @(negedge clk);
    cfg_wr = 1'b0;
  endtask
  task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    cfg_addr = a;
    @(negedge clk);
    `CHK(cfg_rdata, exp)
  endtask
  task automatic wait_idle;
    logic [7:0] s;
    s = 8'hff;
    for (int i = 0; i < 50000 && s[SBA_BUSY_BIT] !== 1'b0; i++)
    begin
      @(negedge clk);
      cfg_addr = SBA_OFF_CTRL;
      @(negedge clk);
      s = cfg_rdata;
    end
    `CHK(s[SBA_BUSY_BIT], 1'b0)
  endtask
  task automatic chk_period(input realtime p);
    realtime t0;
    @(posedge scl_w);
    t0 = $realtime;
    @(posedge scl_w);
    `CHK(($realtime - t0 >= p && $realtime - t0 < p + 100.0), 1'b1)
  endtask
  task automatic chk_all_clear;
    chk_reg(SBA_OFF_VALUE, SBA_RST_VALUE);
    chk_reg(SBA_OFF_INDEX, SBA_RST_INDEX);
    chk_reg(SBA_OFF_TARGET, SBA_RST_TARGET);
    chk_reg(SBA_OFF_CTRL, SBA_RST_CTRL);
    chk_reg(8'h40, 8'h00);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_write_normal;
    wr(SBA_OFF_VALUE, 8'ha5);
    wr(SBA_OFF_INDEX, 8'h3c);
    wr(SBA_OFF_TARGET, {7'h50, 1'b0});
    chk_reg(SBA_OFF_CTRL, 8'h20);
    wr(SBA_OFF_VALUE, 8'hff);
    chk_period(10000.0);
    wait_idle();
    `CHK(i_tgt.mem[8'h3c], 8'ha5)
    `CHK(i_tgt.nb, 3)
    chk_reg(SBA_OFF_VALUE, 8'ha5);
    chk_reg(SBA_OFF_CTRL, 8'h00);
  endtask
  task automatic t_read_fast;
    wr(SBA_OFF_CTRL, 8'h04);
    wr(SBA_OFF_VALUE, 8'h00);
    wr(SBA_OFF_INDEX, 8'h3c);
    wr(SBA_OFF_TARGET, {7'h50, 1'b1});
    chk_period(2500.0);
    wait_idle();
    chk_reg(SBA_OFF_VALUE, 8'ha5);
    `CHK(i_tgt.nb, 2)
    chk_reg(SBA_OFF_CTRL, 8'h04);
  endtask
  task automatic t_nack;
    wr(SBA_OFF_TARGET, {7'h51, 1'b0});
    wait_idle();
    chk_reg(SBA_OFF_CTRL, 8'h06);
    `CHK({scl_w, sda_w}, 2'b11)
    `CHK(i_tgt.nb, 1)
    wr(SBA_OFF_CTRL, 8'h06);
    chk_reg(SBA_OFF_CTRL, 8'h04);
  endtask
  task automatic t_short_stretch;
    stretch_ns = 16'd1500;
    wr(SBA_OFF_CTRL, 8'h84);
    wr(SBA_OFF_VALUE, 8'h77);
    wr(SBA_OFF_TARGET, {7'h50, 1'b0});
    wait_idle();
    `CHK(i_tgt.ptr, 8'h77)
    `CHK(i_tgt.nb, 2)
    wr(SBA_OFF_TARGET, {7'h50, 1'b1});
    wait_idle();
    chk_reg(SBA_OFF_VALUE, 8'h2d);
    `CHK(i_tgt.nb, 2)
    stretch_ns = 16'd0;
  endtask
  task automatic t_reset_mid;
    wr(SBA_OFF_VALUE, 8'h11);
    wr(SBA_OFF_INDEX, 8'h22);
    wr(SBA_OFF_TARGET, {7'h50, 1'b0});
    repeat (300) @(negedge clk);
    rst_n = 1'b0;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    chk_all_clear();
    `CHK({scl_oe, sda_oe}, 2'b00)
    `CHK({scl_out, sda_out}, 2'b00)
  endtask
  // ----------------------------------------------------------------
  // Verdict, watchdog and main sequence
  // ----------------------------------------------------------------
  task automatic tally_and_finish;
    if (n_errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      n_errors++;
      tally_and_finish();
    end
  end
  initial
  begin
    n_errors = 0;
    num_checks = 0;
    cycles = 0;
    rst_n = 1'b0;
    cfg_wr = 1'b0;
    cfg_addr = 8'h00;
    cfg_wdata = 8'h00;
    stretch_ns = 16'd0;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    chk_all_clear();
    t_write_normal();
    t_read_fast();
    t_nack();
    t_short_stretch();
    t_reset_mid();
    tally_and_finish();
  end
endmodule
